// ==== src/clb_defines.svh ====
// Register offsets, field positions, reset values and codes of the class limit binning block
`ifndef CLB_DEFINES_SVH
`define CLB_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CLB_A_CTRL     8'h00
`define CLB_A_CMD      8'h04
`define CLB_A_NOMINAL  8'h08
`define CLB_A_LIMSEL   8'h0C
`define CLB_A_LIMVAL   8'h10
`define CLB_A_STATUS   8'h14
`define CLB_A_MASK     8'h18
`define CLB_A_ERRBUF   8'h1C
`define CLB_A_CMPTYPE  8'h20
`define CLB_A_LIMRD    8'h24
`define CLB_A_CNT0     8'h40
`define CLB_A_CNT8     8'h60
`define CLB_A_TOTAL    8'h64

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CLB_CTRL_CLASSIFY  0
`define CLB_CTRL_REPEAT    1
`define CLB_CTRL_UNIT_LO   2
`define CLB_CTRL_UNIT_HI   4
`define CLB_CMD_COMMIT     0
`define CLB_CMD_CLEAR      1
`define CLB_LSEL_IDX_HI    3
`define CLB_LSEL_PCT       4
`define CLB_LSEL_SUF_LO    5
`define CLB_LSEL_SUF_HI    7
`define CLB_ST_COMMIT      0
`define CLB_ST_EXEC_ERR    4

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define CLB_CTRL_RST       5'h00
`define CLB_UNIT_NONE      3'h0
`define CLB_ERR_NONE       32'h00000000
`define CLB_ERR_PARAM      32'hFFFFFF24
`define CLB_PCT_DIV        64'sh64
`define CLB_RESP_OKAY      2'h0
`define CLB_RESP_SLVERR    2'h2

`endif

// ==== src/clb_pkg.sv ====
// Types shared by the class limit binning block
package clb_pkg;
    typedef logic signed [31:0] clb_val_t;
    typedef logic [31:0]        clb_cnt_t;
    typedef logic [2:0]         clb_unit_t;
    typedef logic [7:0]         clb_addr_t;
    typedef enum logic [0:0] {CLB_RD_IDLE, CLB_RD_DATA} clb_rd_state_t;
endpackage

// ==== src/clb_top.sv ====
// Class limit binning command block with AXI4-Lite register access
//
// How it works
// - Commit copies staged limits to active ones only when all are valid.
// - Failed commit pushes code -220 and sets execution-error status bit 4.
// - After a display unit change, limits entered earlier fail the next commit.
// - Counter registers report classes zero to eight, then the total.
// - A total counter counts every recorded measurement.
// - Repetition mode freezes all statistics counters.
// - A failed measurement leaves every counter unchanged.
// - Statistics clear command zeroes all class counters and the total.
// - Eight limit registers, selected by index one to eight.
// - A limit is absolute or a signed percent deviation from nominal.
// - Limit readback returns the absolute value, never percent form.
// - Limits must rise strictly; any non-increasing pair fails the commit.
// - A limit write accepts an optional unit suffix code or percent.
// - Comparator type reads 1 for classify, 0 for comparator, 0 after reset.
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "clb_defines.svh"

module clb_top (
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire clb_pkg::clb_addr_t AWADDR,
    input  wire logic              AWVALID,
    output logic                   AWREADY,
    input  wire logic [31:0]       WDATA,
    input  wire logic [3:0]        WSTRB,
    input  wire logic              WVALID,
    output logic                   WREADY,
    output logic [1:0]             BRESP,
    output logic                   BVALID,
    input  wire logic              BREADY,
    input  wire clb_pkg::clb_addr_t ARADDR,
    input  wire logic              ARVALID,
    output logic                   ARREADY,
    output logic [31:0]            RDATA,
    output logic [1:0]             RRESP,
    output logic                   RVALID,
    input  wire logic              RREADY,
    input  wire logic              MEAS_VALID,
    input  wire logic              MEAS_FAIL,
    input  wire clb_pkg::clb_val_t MEAS_VALUE,
    output logic                   IRQ
);
    import clb_pkg::*;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ----------------------------------------
    // Bus slave state
    // ----------------------------------------
    logic          aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d;
    logic          awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    clb_addr_t     waddr_q, waddr_d;
    logic [31:0]   wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0]    wstrb_q, wstrb_d;
    logic [1:0]    bresp_q, bresp_d, rresp_q, rresp_d;
    clb_rd_state_t rd_st_q, rd_st_d;
    logic          wr_fire, wr_hit, rd_pop;
    logic [31:0]   rd_word;
    logic          rd_hit;

    // ----------------------------------------
    // Core state
    // ----------------------------------------
    logic [4:0] ctrl_q, ctrl_d;
    clb_val_t   nom_q, nom_d;
    clb_unit_t  nom_unit_q, nom_unit_d;
    logic       nom_set_q, nom_set_d;
    logic [7:0] lsel_q, lsel_d;
    clb_val_t   stg_val_q [8];
    clb_val_t   stg_val_d [8];
    clb_unit_t  stg_unit_q [8];
    clb_unit_t  stg_unit_d [8];
    logic [7:0] stg_ok_q, stg_ok_d;
    clb_val_t   lim_q [8];
    clb_val_t   lim_d [8];
    clb_cnt_t   cnt_q [9];
    clb_cnt_t   cnt_d [9];
    clb_cnt_t   tot_q, tot_d;
    logic [7:0] stat_q, stat_d, mask_q, mask_d;
    logic [31:0] err_q, err_d;
    logic       irq_q, irq_d;

    clb_unit_t   disp_unit, eff_unit;
    logic [3:0]  sel_idx, cls;
    logic        commit_req, clr_req, commit_ok, commit_bad, ordered, meas_inc;
    logic        lim_wr, pct_ok;
    logic signed [63:0] pct_prod, pct_quo;
    clb_val_t    set_val;

    assign disp_unit = ctrl_q[`CLB_CTRL_UNIT_HI:`CLB_CTRL_UNIT_LO];
    assign sel_idx   = lsel_q[`CLB_LSEL_IDX_HI:0];

    // Class number is how many active limits the value reaches; ties go upward
    function automatic logic [3:0] classify(input clb_val_t v, input clb_val_t l [8]);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 8; i++) begin
            if (v >= l[i]) begin
                c = c + 4'h1;
            end
        end
        return c;
    endfunction

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    assign wr_fire = aw_got_q && w_got_q;
    assign rd_pop  = ARVALID && arready_q && (ARADDR == `CLB_A_ERRBUF);

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h00000000;
        case (ARADDR)
            `CLB_A_CTRL:    rd_word = {27'h0000000, ctrl_q};
            `CLB_A_NOMINAL: rd_word = nom_q;
            `CLB_A_LIMSEL:  rd_word = {24'h000000, lsel_q};
            `CLB_A_STATUS:  rd_word = {24'h000000, stat_q};
            `CLB_A_MASK:    rd_word = {24'h000000, mask_q};
            `CLB_A_ERRBUF:  rd_word = err_q;
            `CLB_A_CMPTYPE: rd_word = {31'h00000000, ctrl_q[`CLB_CTRL_CLASSIFY]};
            `CLB_A_LIMRD: begin
                // Percent entries were resolved on entry, so only absolute values return
                if (sel_idx >= 4'h1 && sel_idx <= 4'h8) begin
                    rd_word = stg_val_q[3'(sel_idx - 4'h1)];
                end
            end
            `CLB_A_TOTAL:   rd_word = tot_q;
            `CLB_A_CMD, `CLB_A_LIMVAL: rd_word = 32'h00000000;
            default: begin
                if (ARADDR >= `CLB_A_CNT0 && ARADDR <= `CLB_A_CNT8 && ARADDR[1:0] == 2'h0) begin
                    rd_word = cnt_q[4'(ARADDR[7:2] - 6'h10)];
                end else begin
                    rd_hit = 1'b0;
                end
            end
        endcase
    end

    always_comb begin
        wr_hit = (waddr_q <= `CLB_A_LIMRD) && (waddr_q[1:0] == 2'h0);
        aw_got_d = aw_got_q;
        w_got_d  = w_got_q;
        waddr_d  = waddr_q;
        wdata_d  = wdata_q;
        wstrb_d  = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        rd_st_d  = rd_st_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (AWVALID && awready_q) begin
            aw_got_d = 1'b1;
            waddr_d  = AWADDR;
        end
        if (WVALID && wready_q) begin
            w_got_d = 1'b1;
            wdata_d = WDATA;
            wstrb_d = WSTRB;
        end
        if (wr_fire) begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = wr_hit ? `CLB_RESP_OKAY : `CLB_RESP_SLVERR;
        end else if (bvalid_q && BREADY) begin
            bvalid_d = 1'b0;
        end
        case (rd_st_q)
            CLB_RD_IDLE: begin
                if (ARVALID && arready_q) begin
                    rd_st_d = CLB_RD_DATA;
                    rdata_d = rd_word;
                    rresp_d = rd_hit ? `CLB_RESP_OKAY : `CLB_RESP_SLVERR;
                end
            end
            CLB_RD_DATA: begin
                if (RREADY) begin
                    rd_st_d = CLB_RD_IDLE;
                end
            end
            default: rd_st_d = CLB_RD_IDLE;
        endcase
        awready_d = !aw_got_d && !bvalid_d;
        wready_d  = !w_got_d && !bvalid_d;
        arready_d = (rd_st_d == CLB_RD_IDLE);
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            waddr_q   <= 8'h00;
            wdata_q   <= 32'h00000000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            rd_st_q   <= CLB_RD_IDLE;
            rdata_q   <= 32'h00000000;
            rresp_q   <= 2'h0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
        end else begin
            aw_got_q  <= aw_got_d;
            w_got_q   <= w_got_d;
            waddr_q   <= waddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rd_st_q   <= rd_st_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            arready_q <= arready_d;
        end
    end

    // ----------------------------------------
    // Command, limit and statistics core
    // ----------------------------------------
    always_comb begin
        commit_req = wr_fire && waddr_q == `CLB_A_CMD && wstrb_q[0] && wdata_q[`CLB_CMD_COMMIT];
        clr_req    = wr_fire && waddr_q == `CLB_A_CMD && wstrb_q[0] && wdata_q[`CLB_CMD_CLEAR];
        lim_wr     = wr_fire && waddr_q == `CLB_A_LIMVAL;
        // A missing suffix means the display unit; a different one cannot be used
        eff_unit   = (lsel_q[`CLB_LSEL_SUF_HI:`CLB_LSEL_SUF_LO] == `CLB_UNIT_NONE) ? disp_unit
                     : lsel_q[`CLB_LSEL_SUF_HI:`CLB_LSEL_SUF_LO];
        pct_ok     = !lsel_q[`CLB_LSEL_PCT] || (nom_set_q && nom_unit_q == disp_unit);
        pct_prod   = $signed(nom_q) * $signed(wdata_q);
        pct_quo    = pct_prod / `CLB_PCT_DIV;
        set_val    = lsel_q[`CLB_LSEL_PCT] ? nom_q + clb_val_t'(pct_quo[31:0]) : clb_val_t'(wdata_q);
        ordered    = 1'b1;
        for (int i = 0; i < 7; i++) begin
            if (stg_val_q[i] >= stg_val_q[i+1]) begin
                ordered = 1'b0;
            end
        end
        for (int i = 0; i < 8; i++) begin
            if (stg_unit_q[i] != disp_unit) begin
                ordered = 1'b0;
            end
        end
        commit_ok  = commit_req && ordered && (&stg_ok_q);
        commit_bad = (commit_req && !commit_ok) || (lim_wr && (sel_idx < 4'h1 || sel_idx > 4'h8));
        meas_inc   = MEAS_VALID && !MEAS_FAIL && !ctrl_q[`CLB_CTRL_REPEAT];
        cls        = classify(MEAS_VALUE, lim_q);

        ctrl_d     = ctrl_q;
        nom_d      = nom_q;
        nom_unit_d = nom_unit_q;
        nom_set_d  = nom_set_q;
        lsel_d     = lsel_q;
        stg_ok_d   = stg_ok_q;
        mask_d     = mask_q;
        stat_d     = stat_q;
        err_d      = rd_pop ? `CLB_ERR_NONE : err_q;
        stg_val_d  = stg_val_q;
        stg_unit_d = stg_unit_q;
        lim_d      = lim_q;
        if (wr_fire) begin
            case (waddr_q)
                `CLB_A_CTRL:    ctrl_d = 5'(merge({27'h0000000, ctrl_q}, wdata_q, wstrb_q));
                `CLB_A_NOMINAL: begin
                    nom_d      = merge(nom_q, wdata_q, wstrb_q);
                    nom_unit_d = disp_unit;
                    nom_set_d  = 1'b1;
                end
                `CLB_A_LIMSEL:  lsel_d = 8'(merge({24'h000000, lsel_q}, wdata_q, wstrb_q));
                `CLB_A_STATUS:  stat_d = stat_q & ~wdata_q[7:0];
                `CLB_A_MASK:    mask_d = 8'(merge({24'h000000, mask_q}, wdata_q, wstrb_q));
                default: ;
            endcase
        end
        if (lim_wr && sel_idx >= 4'h1 && sel_idx <= 4'h8) begin
            stg_val_d[3'(sel_idx - 4'h1)]  = set_val;
            stg_unit_d[3'(sel_idx - 4'h1)] = eff_unit;
            stg_ok_d[3'(sel_idx - 4'h1)]   = (eff_unit == disp_unit) && pct_ok;
        end
        if (commit_ok) begin
            lim_d = stg_val_q;
            stat_d[`CLB_ST_COMMIT] = 1'b1;
        end
        // A fresh error wins over a status clear or buffer read in the same cycle
        if (commit_bad) begin
            err_d = `CLB_ERR_PARAM;
            stat_d[`CLB_ST_EXEC_ERR] = 1'b1;
        end
        for (int i = 0; i < 9; i++) begin
            cnt_d[i] = clr_req ? 32'h00000000 : cnt_q[i];
            if (meas_inc && cls == 4'(i)) begin
                cnt_d[i] = cnt_d[i] + 32'h00000001;
            end
        end
        tot_d = clr_req ? 32'h00000000 : tot_q;
        if (meas_inc) begin
            tot_d = tot_d + 32'h00000001;
        end
        irq_d = |(stat_d & mask_d);
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_q     <= `CLB_CTRL_RST;
            nom_q      <= 32'h00000000;
            nom_unit_q <= `CLB_UNIT_NONE;
            nom_set_q  <= 1'b0;
            lsel_q     <= 8'h00;
            stg_ok_q   <= 8'h00;
            stat_q     <= 8'h00;
            mask_q     <= 8'h00;
            err_q      <= `CLB_ERR_NONE;
            tot_q      <= 32'h00000000;
            irq_q      <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                stg_val_q[i]  <= 32'h00000000;
                stg_unit_q[i] <= `CLB_UNIT_NONE;
                lim_q[i]      <= 32'h00000000;
            end
            for (int i = 0; i < 9; i++) begin
                cnt_q[i] <= 32'h00000000;
            end
        end else begin
            ctrl_q     <= ctrl_d;
            nom_q      <= nom_d;
            nom_unit_q <= nom_unit_d;
            nom_set_q  <= nom_set_d;
            lsel_q     <= lsel_d;
            stg_ok_q   <= stg_ok_d;
            stat_q     <= stat_d;
            mask_q     <= mask_d;
            err_q      <= err_d;
            tot_q      <= tot_d;
            irq_q      <= irq_d;
            stg_val_q  <= stg_val_d;
            stg_unit_q <= stg_unit_d;
            lim_q      <= lim_d;
            cnt_q      <= cnt_d;
        end
    end

    assign AWREADY = awready_q;
    assign WREADY  = wready_q;
    assign BVALID  = bvalid_q;
    assign BRESP   = bresp_q;
    assign ARREADY = arready_q;
    assign RVALID  = (rd_st_q == CLB_RD_DATA);
    assign RDATA   = rdata_q;
    assign RRESP   = rresp_q;
    assign IRQ     = irq_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    chk_commit_copies: assert property (commit_ok |=> lim_q[7] == $past(stg_val_q[7]) && stat_q[0])
        else $error("commit did not copy staged limits");
    chk_error_push: assert property (commit_bad |=> err_q == `CLB_ERR_PARAM && stat_q[4])
        else $error("failed commit did not raise parameter error");
    chk_unit_stale: assert property (commit_req && stg_unit_q[0] != disp_unit |=> stat_q[4] && $stable(lim_q[0]))
        else $error("stale unit limits were accepted");
    chk_order_reject: assert property (commit_req && stg_val_q[3] >= stg_val_q[4] |-> !commit_ok ##1 stat_q[4])
        else $error("non increasing limits were accepted");
    chk_total_count: assert property (meas_inc && !clr_req |=> tot_q == $past(tot_q) + 32'h00000001)
        else $error("total did not count measurement");
    chk_repeat_freeze: assert property (ctrl_q[1] && !clr_req |=> $stable(tot_q) && $stable(cnt_q[0]))
        else $error("counters moved in repetition mode");
    chk_fail_freeze: assert property (MEAS_FAIL && !clr_req |=> $stable(tot_q) && $stable(cnt_q[8]))
        else $error("counters moved on failed measurement");
    chk_clear_zero: assert property (clr_req && !meas_inc |=> tot_q == 32'h00000000 && cnt_q[4] == 32'h00000000)
        else $error("statistics clear left counts");
    chk_class_low: assert property (meas_inc && !clr_req && MEAS_VALUE < lim_q[0]
                                    |=> cnt_q[0] == $past(cnt_q[0]) + 32'h00000001)
        else $error("class zero not counted");
    chk_cmp_type: assert property (ARVALID && arready_q && ARADDR == `CLB_A_CMPTYPE
                                   |=> RVALID && RDATA == {31'h00000000, $past(ctrl_q[0])})
        else $error("comparator type readback wrong");
    chk_irq_level: assert property (IRQ == |$past(stat_d & mask_d))
        else $error("interrupt level wrong");

    cov_commit_ok:  cover property (commit_ok ##1 IRQ);
    cov_commit_bad: cover property (commit_bad);
    cov_top_class:  cover property (meas_inc && cls == 4'h8);
    cov_clear:      cover property (clr_req && tot_q != 32'h00000000);

endmodule

`default_nettype wire

// ==== bench/clb_host_model.sv ====
// Remote host model: AXI4-Lite master that carries the block's commands
`timescale 1ns/10ps
`default_nettype none
module clb_host (
    input  wire logic               CLK,
    output clb_pkg::clb_addr_t      AWADDR,
    output logic                    AWVALID,
    input  wire logic               AWREADY,
    output logic [31:0]             WDATA,
    output logic [3:0]              WSTRB,
    output logic                    WVALID,
    input  wire logic               WREADY,
    input  wire logic [1:0]         BRESP,
    input  wire logic               BVALID,
    output logic                    BREADY,
    output clb_pkg::clb_addr_t      ARADDR,
    output logic                    ARVALID,
    input  wire logic               ARREADY,
    input  wire logic [31:0]        RDATA,
    input  wire logic [1:0]         RRESP,
    input  wire logic               RVALID,
    output logic                    RREADY
);
    import clb_pkg::*;
    // ----------------------------------------
    // Bus cycles, each wait bounded
    // ----------------------------------------
    initial begin
        {AWADDR, AWVALID, WDATA, WSTRB, WVALID, BREADY} = '0;
        {ARADDR, ARVALID, RREADY} = '0;
    end
    task automatic wr(input clb_addr_t a, input logic [31:0] d, output logic [1:0] r, output logic ok);
        ok = 1'b0;
        r = 2'h3;
        AWADDR <= a;
        AWVALID <= 1'b1;
        WDATA <= d;
        WSTRB <= 4'hF;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        for (int n = 0; n < 200 && !ok; n++) begin
            @(posedge CLK);
            if (AWVALID && AWREADY) begin
                AWVALID <= 1'b0;
                AWADDR <= ~a;
            end
            // Released data shows the inverse, never the stale word
            if (WVALID && WREADY) begin
                WVALID <= 1'b0;
                WDATA <= ~d;
            end
            if (BVALID && BREADY) begin
                r = BRESP;
                ok = 1'b1;
                BREADY <= 1'b0;
            end
        end
        @(posedge CLK);
    endtask
    task automatic rd(input clb_addr_t a, output logic [31:0] d, output logic [1:0] r, output logic ok);
        ok = 1'b0;
        r = 2'h3;
        d = 32'h0;
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        for (int n = 0; n < 200 && !ok; n++) begin
            @(posedge CLK);
            if (ARVALID && ARREADY) begin
                ARVALID <= 1'b0;
                ARADDR <= ~a;
            end
            if (RVALID && RREADY) begin
                d = RDATA;
                r = RRESP;
                ok = 1'b1;
                RREADY <= 1'b0;
            end
        end
        @(posedge CLK);
    endtask
endmodule
`default_nettype wire

// ==== bench/clb_top_tb.sv ====
// Self-checking bench for the class limit binning block
`timescale 1ns/10ps
`default_nettype none
`include "clb_defines.svh"
module clb_top_tb;
    import clb_pkg::*;
    logic               clk, rst, irq, meas_valid, meas_fail;
    clb_addr_t          awaddr, araddr;
    logic               awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0]        wdata, rdata, rdata_q;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp, resp;
    clb_val_t           meas_value, lim_v;
    clb_val_t           lim_e [1:8];
    clb_val_t           mv [8] = '{32'h32, 32'h64, 32'h4D, 32'h15E, 32'h383, 32'h384, 32'h1388, 32'hFFFFFFF9};
    logic               ok;
    int                 n_fail = 0, cmp_count = 0, tot_e = 0, k;
    int                 cnt_e [0:8];
    clb_top u_clb_top (.CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
        .RVALID(rvalid), .RREADY(rready), .MEAS_VALID(meas_valid), .MEAS_FAIL(meas_fail),
        .MEAS_VALUE(meas_value), .IRQ(irq));
    clb_host u_clb_host (.CLK(clk), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
        .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
        .RREADY(rready));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ----------------------------------------
    // Reporting and bus helpers
    // ----------------------------------------
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_bit(input logic e, input logic g);
        chk_word({31'h0, e}, {31'h0, g});
    endtask
    // A bus wait that ran out ends the run
    task automatic w(input clb_addr_t a, input logic [31:0] d);
        u_clb_host.wr(a, d, resp, ok);
        chk_bit(1'b1, ok);
        if (ok !== 1'b1) wrap_up();
        else chk_word({30'h0, `CLB_RESP_OKAY}, {30'h0, resp});
    endtask
    task automatic rd(input clb_addr_t a, input logic [31:0] e);
        u_clb_host.rd(a, rdata_q, resp, ok);
        chk_bit(1'b1, ok);
        if (ok !== 1'b1) wrap_up();
        else chk_word(e, rdata_q);
    endtask
    // One measurement; the caller names its class from the limits in force
    task automatic meas(input clb_val_t v, input int c);
        meas_valid <= 1'b1;
        meas_value <= v;
        @(posedge clk);
        meas_valid <= 1'b0;
        cnt_e[c]++;
        tot_e++;
    endtask
    function automatic int cls(input clb_val_t v);
        cls = 0;
        for (int i = 1; i <= 8; i++) cls += (lim_e[i] <= v);
    endfunction
    task automatic chk_counts();
        for (int c = 0; c <= 8; c++) rd(`CLB_A_CNT0 + 8'(4 * c), 32'(cnt_e[c]));
        rd(`CLB_A_TOTAL, 32'(tot_e));
    endtask
    // Limits rise by 100 per step; index bad repeats its neighbour, limit 8 is entered as -10 percent
    task automatic set_limits(input int bad);
        w(`CLB_A_NOMINAL, 32'h3E8);
        for (int i = 1; i <= 8; i++) begin
            lim_v = (i == bad) ? 32'(100 * (i - 1)) : 32'(100 * i);
            w(`CLB_A_LIMSEL, 32'(i));
            w(`CLB_A_LIMVAL, lim_v);
        end
        w(`CLB_A_LIMSEL, 32'h18);
        w(`CLB_A_LIMVAL, 32'hFFFFFFF6);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        {meas_valid, meas_fail, meas_value} = '0;
        cnt_e = '{default: 0};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(`CLB_A_CMPTYPE, 32'h0);
        rd(8'h30, 32'h0);
        chk_word({30'h0, `CLB_RESP_SLVERR}, {30'h0, resp});
        w(`CLB_A_CTRL, 32'h05);
        rd(`CLB_A_CMPTYPE, 32'h1);
        w(`CLB_A_MASK, 32'h11);
        set_limits(0);
        w(`CLB_A_LIMSEL, 32'h1);
        rd(`CLB_A_LIMRD, 32'h64);
        w(`CLB_A_LIMSEL, 32'h8);
        rd(`CLB_A_LIMRD, 32'h384);
        w(`CLB_A_CMD, 32'h1);
        for (int i = 1; i <= 8; i++) lim_e[i] = (i == 8) ? 32'h384 : 32'(100 * i);
        rd(`CLB_A_STATUS, 32'h1);
        chk_bit(1'b1, irq);
        rd(`CLB_A_ERRBUF, `CLB_ERR_NONE);
        foreach (mv[i]) begin
            meas_valid <= 1'b1;
            meas_value <= mv[i];
            meas_fail <= (i == 2);
            if (i != 2) begin
                k = cls(mv[i]);
                cnt_e[k]++;
                tot_e++;
            end
            @(posedge clk);
        end
        meas_valid <= 1'b0;
        meas_value <= 32'h5A5A5A5A;
        w(`CLB_A_CTRL, 32'h07);
        meas_valid <= 1'b1;
        repeat (2) @(posedge clk);
        meas_valid <= 1'b0;
        w(`CLB_A_CTRL, 32'h05);
        chk_counts();
        w(`CLB_A_CMD, 32'h2);
        cnt_e = '{default: 0};
        tot_e = 0;
        chk_counts();
        w(`CLB_A_CTRL, 32'h09);
        w(`CLB_A_CMD, 32'h1);
        rd(`CLB_A_ERRBUF, `CLB_ERR_PARAM);
        rd(`CLB_A_ERRBUF, `CLB_ERR_NONE);
        rd(`CLB_A_STATUS, 32'h11);
        w(`CLB_A_STATUS, 32'h11);
        rd(`CLB_A_STATUS, 32'h0);
        chk_bit(1'b0, irq);
        w(`CLB_A_MASK, 32'h0);
        set_limits(5);
        w(`CLB_A_CMD, 32'h1);
        rd(`CLB_A_STATUS, 32'h10);
        rd(`CLB_A_ERRBUF, `CLB_ERR_PARAM);
        chk_bit(1'b0, irq);
        // 450 lands in class 4 under the old limits, class 5 had the bad set been copied
        meas(32'h1C2, 4);
        chk_counts();
        w(`CLB_A_LIMSEL, 32'h45);
        w(`CLB_A_LIMVAL, 32'h1C2);
        w(`CLB_A_CMD, 32'h1);
        rd(`CLB_A_STATUS, 32'h11);
        meas(32'h1C2, 5);
        chk_counts();
        w(`CLB_A_LIMSEL, 32'h25);
        w(`CLB_A_LIMVAL, 32'h1C2);
        w(`CLB_A_CMD, 32'h1);
        rd(`CLB_A_ERRBUF, `CLB_ERR_PARAM);
        w(`CLB_A_LIMSEL, 32'h9);
        w(`CLB_A_LIMVAL, 32'h0);
        rd(`CLB_A_ERRBUF, `CLB_ERR_PARAM);
        wrap_up();
    end
endmodule
`default_nettype wire
